/* sad_pkg.sv */
package sad_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [11:0] SAD_RESULT_BASE = 12'h000;
    localparam logic [11:0] SAD_CTRL_OFS = 12'h020;
    localparam logic [11:0] SAD_CHEN_OFS = 12'h024;
    localparam logic [11:0] SAD_CMP_OFS = 12'h028;
    localparam logic [11:0] SAD_STATUS_OFS = 12'h02c;
    localparam logic [11:0] SAD_ICLR_OFS = 12'h030;
    localparam logic [11:0] SAD_IEN_OFS = 12'h034;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int SAD_CH_N = 8;
    localparam int SAD_DIFF_N = 4;
    localparam int SAD_RES_W = 12;
    localparam int SAD_EVT_N = 3;
    localparam logic [2:0] SAD_LAST_CH = 3'h7;
    localparam int SAD_RES_OVR_BIT = 16;
    localparam int SAD_RES_VLD_BIT = 17;
    localparam int SAD_CTRL_EN_BIT = 0;
    localparam int SAD_CTRL_MODE_LSB = 2;
    localparam int SAD_CTRL_TRIG_BIT = 4;
    localparam int SAD_CTRL_DIFF_BIT = 6;
    localparam int SAD_CTRL_SRC_LSB = 8;
    localparam int SAD_CTRL_START_BIT = 11;
    localparam int SAD_CTRL_CAL_BIT = 12;
    localparam int SAD_CMP_EN_BIT = 16;
    localparam int SAD_STAT_BUSY_BIT = 8;
    localparam int SAD_STAT_CAL_BIT = 9;
    localparam int SAD_STAT_VLD_LSB = 16;

    // Interrupt event bit positions
    localparam int SAD_EVT_DONE = 0;
    localparam int SAD_EVT_MATCH = 1;
    localparam int SAD_EVT_CAL = 2;

    // ****************************************************************
    // Modes and channel 7 sources
    // ****************************************************************
    localparam logic [1:0] SAD_MODE_SINGLE = 2'h0;
    localparam logic [1:0] SAD_MODE_SCAN_ONCE = 2'h2;
    localparam logic [1:0] SAD_MODE_SCAN_CONT = 2'h3;
    localparam logic [1:0] SAD_SRC_PIN = 2'h0;
    localparam logic [1:0] SAD_SRC_BANDGAP = 2'h1;
    localparam logic [1:0] SAD_SRC_TEMP = 2'h2;
    localparam logic [1:0] SAD_SRC_GND = 2'h3;

    typedef enum logic [1:0] {
        SAD_IDLE,
        SAD_CAL,
        SAD_START,
        SAD_WAIT
    } sad_state_e;

endpackage : sad_pkg

/* sad_trig_sync.sv */
module sad_trig_sync
    import sad_pkg::*;
(
    input wire logic ref_clk, // Converter clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic pin, // Raw external trigger pin
    output logic rise_q // One-cycle pulse on a filtered rising edge
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
    } sad_sync_s;

    sad_sync_s q;
    sad_sync_s d;

    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.rise = 1'b0;
        // A change counts only once the second and third stages agree
        if (q.s2 == q.s3) begin
            d.level = q.s3;
            d.rise = q.s3 & ~q.level;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign rise_q = q.rise;

endmodule // sad_trig_sync

/* sad_sequencer.sv */
// Overview of operation
// RL1 - Sequence 12-bit converter over eight channels
// RL2 - Eight single-ended or four differential pairs
// RL3 - Single mode converts one channel, stops
// RL4 - Single-cycle scan: enabled channels low-to-high once
// RL5 - Continuous scan repeats until software halts
// RL6 - Writing start bit one begins conversion
// RL7 - External trigger pin can also start
// RL8 - Per-channel result with valid and overrun
// RL9 - Equal compare match raises enabled interrupt
// RL10 - Channel 7 selects one of four sources
// RL11 - Self-calibration sequence before normal conversions
// RL12 - Valid set on write, cleared on read
// RL13 - Start bit holds while busy, self-clears
//
// Local design decisions: the APB register port and the address map.
module sad_sequencer
    import sad_pkg::*;
(
    input wire logic ref_clk, // Converter clock, 10 MHz
    input wire logic reset, // Asynchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic external_trigger_pin, // External start pin
    output logic adc_go, // One-cycle start pulse to the analog core
    output logic [2:0] adc_chan, // Channel or pair under conversion
    output logic adc_diff, // Differential pair mode
    output logic [1:0] adc_ch7_src, // Channel 7 source select
    input wire logic adc_done, // Core result ready, one-cycle pulse
    input wire logic [11:0] adc_result, // Core result, valid with adc_done
    output logic cal_go, // One-cycle calibration start pulse
    input wire logic cal_done, // Calibration finished, one-cycle pulse
    output logic irq // Level interrupt
);

    typedef struct packed {
        sad_state_e state;
        logic en;
        logic [1:0] mode;
        logic trig_en;
        logic diff;
        logic [1:0] ch7_src;
        logic start;
        logic cal;
        logic [SAD_CH_N-1:0] chen;
        logic [SAD_RES_W-1:0] cmp_val;
        logic cmp_en;
        logic [SAD_CH_N-1:0][SAD_RES_W-1:0] res;
        logic [SAD_CH_N-1:0] valid;
        logic [SAD_CH_N-1:0] ovr;
        logic [SAD_EVT_N-1:0] ists;
        logic [SAD_EVT_N-1:0] ien;
        logic [2:0] cur;
        logic adc_go;
        logic cal_go;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic irq;
    } sad_seq_s;

    sad_seq_s q;
    sad_seq_s d;
    logic trig_rise;

    // ****************************************************************
    // External trigger conditioning
    // ****************************************************************
    sad_trig_sync u_trig (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin(external_trigger_pin),
        .rise_q(trig_rise)
    );

    // Lowest enabled channel at or above 'from'; bit 3 of the answer flags a hit
    // Priority falls to the lowest index because the loop runs downward
    function automatic logic [3:0] next_chan(input logic [SAD_CH_N-1:0] en,
                                             input logic [3:0] from);
        logic [3:0] r;
        r = '0;
        for (int i = SAD_CH_N - 1; i >= 0; i--) begin
            if (en[i] && (4'(i) >= from)) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // Register read mux, for a mapped address only
    function automatic logic [31:0] rd_mux(input sad_seq_s s, input logic [11:0] a);
        logic [31:0] r;
        r = '0;
        if (a < SAD_CTRL_OFS) begin
            r[SAD_RES_W-1:0] = s.res[a[4:2]];
            r[SAD_RES_OVR_BIT] = s.ovr[a[4:2]];
            r[SAD_RES_VLD_BIT] = s.valid[a[4:2]];
        end else if (a == SAD_CTRL_OFS) begin
            r[SAD_CTRL_EN_BIT] = s.en;
            r[SAD_CTRL_MODE_LSB +: 2] = s.mode;
            r[SAD_CTRL_TRIG_BIT] = s.trig_en;
            r[SAD_CTRL_DIFF_BIT] = s.diff;
            r[SAD_CTRL_SRC_LSB +: 2] = s.ch7_src;
            r[SAD_CTRL_START_BIT] = s.start;
            r[SAD_CTRL_CAL_BIT] = s.cal;
        end else if (a == SAD_CHEN_OFS) begin
            r[SAD_CH_N-1:0] = s.chen;
        end else if (a == SAD_CMP_OFS) begin
            r[SAD_RES_W-1:0] = s.cmp_val;
            r[SAD_CMP_EN_BIT] = s.cmp_en;
        end else if (a == SAD_STATUS_OFS) begin
            r[SAD_EVT_N-1:0] = s.ists;
            r[SAD_STAT_BUSY_BIT] = s.start;
            r[SAD_STAT_CAL_BIT] = s.cal;
            r[SAD_STAT_VLD_LSB +: SAD_CH_N] = s.valid;
        end else if (a == SAD_IEN_OFS) begin
            r[SAD_EVT_N-1:0] = s.ien;
        end
        return r;
    endfunction

    always_comb begin
        logic hit;
        logic xfer;
        logic wr;
        logic rd_res;
        logic kick;
        logic halt;
        logic [SAD_CH_N-1:0] usable;
        logic [3:0] nx;
        logic [2:0] ridx;
        hit = 1'b0;
        xfer = 1'b0;
        wr = 1'b0;
        rd_res = 1'b0;
        kick = 1'b0;
        halt = 1'b0;
        usable = '0;
        nx = '0;
        ridx = '0;
        d = q;
        d.adc_go = 1'b0;
        d.cal_go = 1'b0;

        // ************************************************************
        // APB slave: one wait state, so read data comes from a flop
        // ************************************************************
        // Unaligned or unmapped addresses answer with an error and change nothing
        hit = (paddr[1:0] == 2'h0) && ((paddr < SAD_ICLR_OFS) || (paddr == SAD_ICLR_OFS) ||
              (paddr == SAD_IEN_OFS));
        xfer = psel & penable & q.pready;
        wr = xfer & pwrite & hit;
        rd_res = xfer & ~pwrite & hit & (paddr < SAD_CTRL_OFS);
        ridx = paddr[4:2];
        d.pready = psel & penable & ~q.pready;
        d.pslverr = psel & penable & ~q.pready & ~hit;
        d.prdata = (psel & penable & ~q.pready & ~pwrite & hit) ? rd_mux(q, paddr) : '0;

        // Reading a result consumes it
        if (rd_res) begin
            d.valid[ridx] = 1'b0; // RL12
            d.ovr[ridx] = 1'b0;
        end

        if (wr && paddr == SAD_CTRL_OFS) begin
            d.en = pwdata[SAD_CTRL_EN_BIT];
            d.mode = pwdata[SAD_CTRL_MODE_LSB +: 2]; // RL3 RL4 RL5
            d.trig_en = pwdata[SAD_CTRL_TRIG_BIT];
            d.diff = pwdata[SAD_CTRL_DIFF_BIT]; // RL2
            d.ch7_src = pwdata[SAD_CTRL_SRC_LSB +: 2]; // RL10
            if (pwdata[SAD_CTRL_START_BIT]) begin
                kick = 1'b1; // RL6
            end else begin
                halt = 1'b1; // RL5
            end
            if (pwdata[SAD_CTRL_CAL_BIT] && q.state == SAD_IDLE && !q.start) begin
                d.cal = 1'b1;
                d.cal_go = 1'b1;
                d.state = SAD_CAL; // RL11
                kick = 1'b0;
            end
        end
        if (wr && paddr == SAD_CHEN_OFS) begin
            d.chen = pwdata[SAD_CH_N-1:0];
        end
        if (wr && paddr == SAD_CMP_OFS) begin
            d.cmp_val = pwdata[SAD_RES_W-1:0];
            d.cmp_en = pwdata[SAD_CMP_EN_BIT];
        end
        if (wr && paddr == SAD_ICLR_OFS) begin
            d.ists = q.ists & ~pwdata[SAD_EVT_N-1:0];
        end
        if (wr && paddr == SAD_IEN_OFS) begin
            d.ien = pwdata[SAD_EVT_N-1:0];
        end

        if (q.trig_en && trig_rise) begin
            kick = 1'b1; // RL7
        end
        // Disabling the converter stops any conversion in flight
        if (!d.en) begin
            halt = 1'b1;
            kick = 1'b0;
        end

        // In pair mode only the four pair indices take part
        usable = d.diff ? {{(SAD_CH_N-SAD_DIFF_N){1'b0}}, d.chen[SAD_DIFF_N-1:0]} : d.chen; // RL2

        // ************************************************************
        // Conversion sequencer
        // ************************************************************
        unique case (q.state)
            SAD_IDLE: begin
                if (kick && d.state == SAD_IDLE) begin
                    nx = next_chan(usable, 4'h0); // RL4
                    if (nx[3]) begin
                        d.cur = nx[2:0];
                        d.start = 1'b1; // RL13
                        d.state = SAD_START;
                    end else begin
                        d.start = 1'b0;
                    end
                end
            end
            SAD_CAL: begin
                // Calibration cannot be aborted; the core must finish it
                if (cal_done) begin
                    d.cal = 1'b0;
                    d.ists[SAD_EVT_CAL] = 1'b1;
                    d.state = SAD_IDLE;
                end
            end
            SAD_START: begin
                d.adc_go = 1'b1; // RL1
                d.state = SAD_WAIT;
            end
            SAD_WAIT: begin
                if (adc_done) begin
                    d.res[q.cur] = adc_result; // RL8
                    // Unread old result replaced, unless read this very cycle
                    d.ovr[q.cur] = (q.ovr[q.cur] | q.valid[q.cur]) &
                                   ~(rd_res && ridx == q.cur); // RL12
                    d.valid[q.cur] = 1'b1; // RL12
                    if (q.cmp_en && adc_result == q.cmp_val) begin
                        d.ists[SAD_EVT_MATCH] = 1'b1; // RL9
                    end
                    nx = '0;
                    if ((q.mode inside {SAD_MODE_SCAN_ONCE, SAD_MODE_SCAN_CONT}) &&
                        q.cur != SAD_LAST_CH) begin
                        nx = next_chan(usable, {1'b0, q.cur} + 4'h1); // RL4
                    end
                    if (!nx[3] && q.mode == SAD_MODE_SCAN_CONT) begin
                        nx = next_chan(usable, 4'h0); // RL5
                        d.ists[SAD_EVT_DONE] = 1'b1;
                    end
                    if (nx[3]) begin
                        d.cur = nx[2:0];
                        d.state = SAD_START;
                    end else begin
                        d.start = 1'b0; // RL13 RL3
                        d.ists[SAD_EVT_DONE] = 1'b1;
                        d.state = SAD_IDLE;
                    end
                end
            end
        endcase

        // Checked on the next state so that a calibration request is not
        // cancelled by the halt that its own start-bit-clear write raises
        if (halt && d.state != SAD_CAL) begin
            d.start = 1'b0;
            d.state = SAD_IDLE;
        end

        d.irq = |(d.ists & d.ien); // RL9
    end

    // ****************************************************************
    // Register stage
    // ****************************************************************
    // Reset leaves the sequencer idle in single mode with channel 7 on its pin
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            q <= '{state: SAD_IDLE, ch7_src: SAD_SRC_PIN, mode: SAD_MODE_SINGLE, default: '0};
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Every output comes straight from a flop of the state record
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign adc_go = q.adc_go;
    assign adc_chan = q.cur; // RL1
    assign adc_diff = q.diff;
    assign adc_ch7_src = q.ch7_src; // RL10
    assign cal_go = q.cal_go;
    assign irq = q.irq;

endmodule // sad_sequencer

/* sad_sva.sv */
module sad_sva (
    input wire logic ref_clk, // clock
    input wire logic reset, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic adc_go, // start
    input wire logic [2:0] adc_chan, // channel
    input wire logic adc_done, // done
    input wire logic cal_go // calibrate
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    sequence s_go;
        adc_go;
    endsequence
    // Core needs at least four cycles, so the channel must not move before then
    sequence s_hold;
        $stable(adc_chan) [*3];
    endsequence
    a_ready_wait: assert property (psel && $rose(penable) |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready long");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready unasked");
    a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata idle");
    a_go_pulse: assert property (s_go |=> !adc_go)
        else $error("go long");
    a_chan_hold: assert property (s_go |=> s_hold)
        else $error("chan moved");
    a_done_gap: assert property (adc_done |=> !adc_go)
        else $error("go early");
    a_cal_pulse: assert property (cal_go |=> !cal_go && !adc_go)
        else $error("cal long");
endmodule // sad_sva

bind sad_sequencer sad_sva u_sva (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_go(adc_go), .adc_chan(adc_chan), .adc_done(adc_done), .cal_go(cal_go));

/* sad_core_model.sv */
module sad_core_model (
    input wire logic ref_clk, // clock
    input wire logic reset, // reset
    input wire logic adc_go, // start
    input wire logic [2:0] adc_chan, // channel
    input wire logic adc_diff, // pair mode
    input wire logic [1:0] adc_ch7_src, // ch7 source
    input wire logic cal_go, // calibrate
    input wire logic slow, // long conversions
    input wire logic [11:0] res_base, // analog level
    output logic adc_done, // result ready
    output logic [11:0] adc_result, // result
    output logic cal_done // calibration ready
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    int ccnt;
    // Result bus toggles outside the done pulse so a late sample is seen
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt <= 0;
            ccnt <= 0;
            adc_done <= 1'b0;
            adc_result <= 12'h0;
            cal_done <= 1'b0;
        end else begin
            adc_done <= (cnt == 1);
            adc_result <= (cnt == 1) ? res_base ^ {adc_diff, adc_ch7_src, 6'h0, adc_chan}
                : ~adc_result;
            cal_done <= (ccnt == 1);
            cnt <= adc_go ? (slow ? 9 : 4) : (cnt != 0 ? cnt - 1 : 0);
            ccnt <= cal_go ? 12 : (ccnt != 0 ? ccnt - 1 : 0);
        end
    end
endmodule // sad_core_model

/* sad_sequencer_tb.sv */
module sad_sequencer_tb
    import sad_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, reset, psel, penable, pwrite, pin, slow;
    logic pready, pslverr, adc_go, adc_diff, adc_done, cal_go, cal_done, irq;
    logic [11:0] paddr, adc_result, res_base, b;
    logic [31:0] pwdata, prdata;
    logic [2:0] adc_chan;
    logic [1:0] adc_ch7_src;
    logic [65:0] eq[$];
    logic [2:0] chq[$];
    int error_cnt = 0;
    int n_checks = 0;
    int seed = 32'h06f6517a;
    int n;

    always #50 ref_clk = ~ref_clk;

    sad_sequencer dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_trigger_pin(pin), .adc_go(adc_go), .adc_chan(adc_chan),
        .adc_diff(adc_diff), .adc_ch7_src(adc_ch7_src), .adc_done(adc_done),
        .adc_result(adc_result), .cal_go(cal_go), .cal_done(cal_done), .irq(irq));
    sad_core_model u_core (.ref_clk(ref_clk), .reset(reset), .adc_go(adc_go),
        .adc_chan(adc_chan), .adc_diff(adc_diff), .adc_ch7_src(adc_ch7_src), .cal_go(cal_go),
        .slow(slow), .res_base(res_base), .adc_done(adc_done), .adc_result(adc_result),
        .cal_done(cal_done));

    task automatic report_and_stop();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cmp_bus(input logic [32:0] e, input logic [32:0] g, input logic [32:0] m);
        n_checks++;
        if (((g ^ e) & m) !== 33'h0) begin
            error_cnt++;
            $display("ERROR apb exp %h got %h", e, g);
        end
    endtask

    task automatic cmp_chan(input logic [2:0] e, input logic [2:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR adc_chan exp %h got %h", e, g);
        end
    endtask

    // Expectation is queued at setup; the monitor pops it when pready shows
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
        input logic [32:0] e, input logic [32:0] m);
        int k;
        @(posedge ref_clk);
        eq.push_back({m, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            $display("ERROR pready exp 1 got %b", pready);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 33'h0, '1);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        apb(a, 1'b0, 32'h0, {1'b0, e}, {1'b1, m});
    endtask

    task automatic wait_irq();
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge ref_clk);
            n++;
        end
        if (irq !== 1'b1) begin
            error_cnt++;
            $display("ERROR irq exp 1 got %b", irq);
        end
    endtask

    function automatic logic [31:0] ctl(logic [1:0] md, logic [1:0] s, logic df, logic tg,
        logic st);
        return 32'h1 | 32'(md) << SAD_CTRL_MODE_LSB | 32'(tg) << SAD_CTRL_TRIG_BIT
            | 32'(df) << SAD_CTRL_DIFF_BIT | 32'(s) << SAD_CTRL_SRC_LSB
            | 32'(st) << SAD_CTRL_START_BIT;
    endfunction

    function automatic logic [31:0] rv(logic v, logic o, logic [2:0] c, logic [1:0] s);
        return {14'h0, v, o, 4'h0, b ^ {1'b0, s, 6'h0, c}};
    endfunction

    function automatic logic [11:0] ra(logic [2:0] c);
        return SAD_RESULT_BASE + {7'h0, c, 2'h0};
    endfunction

    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && eq.size() > 0) begin
            cmp_bus(eq[0][32:0], {pslverr, prdata}, eq[0][65:33]);
            eq.delete(0);
        end
        if (adc_go === 1'b1) begin
            cmp_chan(chq.size() > 0 ? chq[0] : 3'hx, adc_chan);
            if (chq.size() > 0) chq.delete(0);
        end
    end

    initial begin
        #3000000;
        error_cnt++;
        $display("ERROR watchdog exp end got hang");
        report_and_stop();
    end

    // ********
    // Main sequence
    // ********
    initial begin
        {ref_clk, psel, penable, pwrite, pin, slow} = 6'h0;
        reset = 1'b1;
        {paddr, pwdata, res_base, b} = 68'h0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        rd(SAD_CTRL_OFS, 32'h0, '1);
        rd(SAD_STATUS_OFS, 32'h0, '1);
        apb(12'h038 + 12'($random(seed) & 32'h7), 1'b0, 32'h0, {1'b1, 32'h0}, '1);
        b = 12'($random(seed));
        res_base <= b;
        wr(SAD_IEN_OFS, 32'h1);
        wr(SAD_CHEN_OFS, 32'h24);
        chq.push_back(3'h2);
        wr(SAD_CTRL_OFS, ctl(SAD_MODE_SINGLE, SAD_SRC_PIN, 1'b0, 1'b0, 1'b1));
        wait_irq();
        rd(SAD_CTRL_OFS, 32'h0, 32'h800);
        rd(ra(3'h2), rv(1'b1, 1'b0, 3'h2, 2'h0), '1);
        rd(ra(3'h2), 32'h0, 32'h30000);
        wr(SAD_ICLR_OFS, 32'h7);
        wr(SAD_CHEN_OFS, 32'h81);
        for (int s = 0; s < 4; s++) begin
            b = 12'($random(seed));
            res_base <= b;
            slow <= 1'($random(seed));
            wr(SAD_CMP_OFS, 32'h10000 | 32'(b ^ {1'b0, 2'(s), 9'h7}));
            chq.push_back(3'h0);
            chq.push_back(3'h7);
            wr(SAD_CTRL_OFS, ctl(SAD_MODE_SCAN_ONCE, 2'(s), 1'b0, 1'b0, 1'b1));
            wait_irq();
            rd(SAD_STATUS_OFS, 32'h00810003, '1);
            rd(ra(3'h7), rv(1'b1, 1'b0, 3'h7, 2'(s)), '1);
            wr(SAD_ICLR_OFS, 32'h1);
            wr(SAD_IEN_OFS, 32'h2);
            wait_irq();
            wr(SAD_ICLR_OFS, 32'h2);
            wr(SAD_IEN_OFS, 32'h1);
        end
        rd(ra(3'h0), rv(1'b1, 1'b1, 3'h0, 2'h3), '1);
        slow <= 1'b1;
        wr(SAD_CHEN_OFS, 32'h0a);
        repeat (3) chq.push_back(3'h1);
        for (int i = 0; i < 3; i++) chq.insert(2 * i + 1, 3'h3);
        wr(SAD_CTRL_OFS, ctl(SAD_MODE_SCAN_CONT, 2'h0, 1'b1, 1'b0, 1'b1));
        n = 0;
        while (chq.size() > 0 && n < 500) begin
            @(posedge ref_clk);
            n++;
        end
        wr(SAD_CTRL_OFS, ctl(SAD_MODE_SCAN_CONT, 2'h0, 1'b1, 1'b0, 1'b0));
        rd(SAD_STATUS_OFS, 32'h1, 32'h301);
        wr(SAD_ICLR_OFS, 32'h7);
        slow <= 1'b0;
        wr(SAD_CHEN_OFS, 32'h10);
        chq.push_back(3'h4);
        wr(SAD_CTRL_OFS, ctl(2'h1, 2'h0, 1'b0, 1'b1, 1'b0));
        pin <= 1'b1;
        repeat (6) @(posedge ref_clk);
        pin <= 1'b0;
        wait_irq();
        wr(SAD_ICLR_OFS, 32'h7);
        wr(SAD_IEN_OFS, 32'h4);
        wr(SAD_CTRL_OFS, 32'h1 | 32'h1 << SAD_CTRL_CAL_BIT);
        wait_irq();
        rd(SAD_STATUS_OFS, 32'h4, 32'h307);
        wr(SAD_CHEN_OFS, 32'h0);
        wr(SAD_CTRL_OFS, ctl(SAD_MODE_SINGLE, 2'h0, 1'b0, 1'b0, 1'b1));
        rd(SAD_CTRL_OFS, 32'h0, 32'h800);
        repeat (4) @(posedge ref_clk);
        cmp_chan(3'(eq.size() + chq.size()), 3'h0);
        report_and_stop();
    end
endmodule // sad_sequencer_tb
